// [uart_stat_defines.vh]
`ifndef UART_STAT_DEFINES_VH
`define UART_STAT_DEFINES_VH
// ==========================================================================
// Register map (byte addresses, chosen)
`define REG_STATUS_CONTROL 5'h00
`define REG_TX_DATA        5'h04
`define REG_RX_DATA        5'h08
`define REG_IRQ_STATUS     5'h0C
`define REG_IRQ_MASK       5'h10
`define REG_MODE           5'h14
`define REG_BAUD_DIV       5'h18
// ==========================================================================
// Status/control field positions
`define BIT_TX_MODE_HI     15
`define BIT_TX_IDLE_INV    14
`define BIT_TX_MODE_LO     13
`define BIT_BREAK_REQ      11
`define BIT_TX_ENABLE      10
`define BIT_TX_FULL        9
`define BIT_TX_SHIFT_EMPTY 8
`define BIT_RX_SEL_HI      7
`define BIT_RX_SEL_LO      6
`define BIT_RX_AVAIL       0
// Interrupt status bits
`define IRQ_TX             0
`define IRQ_RX             1
// ==========================================================================
// Sizes and reset values
`define FIFO_DEPTH         3'h4
`define BREAK_ZEROS        12
`define BAUD_DIV_RESET     16'h00AD
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2
`endif

// [uart_stat.v]
// The AXI4-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "uart_stat_defines.vh"
module uart_stat (
   // Clock and reset
   input  wire        clk_sys,
   input  wire        rst_n,
   // AXI4-Lite write
   input  wire [4:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // AXI4-Lite read
   input  wire [4:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // Serial lines
   input  wire        serial_rx_pin,
   output reg         serial_tx_pin,
   output wire        serial_tx_oe_n,
   // General-purpose port value used when the serial logic lets go
   input  wire        port_tx_value,
   // Interrupt
   output wire        irq
);
   // =======================================================================
   // Registers
   reg  [1:0]  tx_irq_mode_select_q;
   reg         tx_idle_invert_q;
   reg         send_break_request_q;
   reg         tx_enable_q;
   reg  [1:0]  rx_irq_level_select_q;
   reg         infrared_encode_enable_q;
   reg  [15:0] baud_div_q;
   reg  [1:0]  irq_status_q;
   reg  [1:0]  irq_mask_q;
   reg  [7:0]  tx_fifo_q [0:3];
   reg  [1:0]  tx_rd_q;
   reg  [2:0]  tx_cnt_q;
   reg  [7:0]  rx_fifo_q [0:3];
   reg  [1:0]  rx_rd_q;
   reg  [2:0]  rx_cnt_q;
   reg         aw_held_q;
   reg  [4:0]  aw_addr_q;
   reg         w_held_q;
   reg  [31:0] w_data_q;
   reg  [3:0]  w_strb_q;
   reg  [15:0] tx_baud_q;
   reg  [3:0]  tx_bit_q;      // 0 idle, 1 start, 2..N data, last stop
   reg  [11:0] tx_shift_q;
   reg         tx_busy_q;
   reg         tx_is_break_q;
   reg         tx_line_q;
   reg  [15:0] rx_baud_q;
   reg  [3:0]  rx_bit_q;
   reg  [7:0]  rx_shift_q;
   reg         rx_busy_q;
   // =======================================================================
   // Bus handshakes: one write and one read in flight
   wire wr_go  = aw_held_q & w_held_q & ~s_axi_bvalid;
   assign s_axi_awready = ~aw_held_q & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_held_q & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;
   wire rd_go = s_axi_arvalid & s_axi_arready;
   wire [4:0] wa = aw_addr_q;
   wire wr_ctl   = wr_go & (wa == `REG_STATUS_CONTROL);
   wire wr_txd   = wr_go & (wa == `REG_TX_DATA) & w_strb_q[0];
   wire wr_iclr  = wr_go & (wa == `REG_IRQ_STATUS) & w_strb_q[0];
   wire wr_mask  = wr_go & (wa == `REG_IRQ_MASK) & w_strb_q[0];
   wire wr_mode  = wr_go & (wa == `REG_MODE) & w_strb_q[0];
   wire wr_baud  = wr_go & (wa == `REG_BAUD_DIV);
   wire rd_rxd   = rd_go & (s_axi_araddr == `REG_RX_DATA);
   wire wa_ok    = (wa <= `REG_BAUD_DIV) & (wa[1:0] == 2'h0);
   wire ra_ok    = (s_axi_araddr <= `REG_BAUD_DIV) & (s_axi_araddr[1:0] == 2'h0);
   // =======================================================================
   // Status terms
   // full flag
   wire tx_full        = (tx_cnt_q == `FIFO_DEPTH);
   // empty only when idle and drained
   wire tx_shift_empty = ~tx_busy_q & (tx_cnt_q == 3'h0);
   wire tx_tick        = (tx_baud_q == 16'h0000);
   wire tx_last        = tx_busy_q & tx_tick & (tx_bit_q == (tx_is_break_q ? 4'hE : 4'hA));
   // Load shift register from buffer, or send break even when buffer empty
   wire tx_load = tx_enable_q & ~tx_busy_q & ((tx_cnt_q != 3'h0) | send_break_request_q);
   wire tx_load_chr = tx_load & ~send_break_request_q;
   wire rx_tick  = (rx_baud_q == 16'h0000);
   wire rx_done  = rx_busy_q & rx_tick & (rx_bit_q == 4'h9);
   wire rx_push  = rx_done & serial_rx_pin & (rx_cnt_q != `FIFO_DEPTH);
   wire [2:0] rx_cnt_after = rx_cnt_q + 3'h1;
   // Transmit event by mode
   reg tx_evt;
   always @* begin
      case (tx_irq_mode_select_q)
         2'b00:   tx_evt = tx_load_chr;
         2'b01:   tx_evt = tx_last & (tx_cnt_q == 3'h0);
         2'b10:   tx_evt = tx_load_chr & (tx_cnt_q == 3'h1);
         default: tx_evt = 1'b0;
      endcase
   end
   // Receive event by threshold
   reg rx_evt;
   always @* begin
      case (rx_irq_level_select_q)
         2'b11:   rx_evt = rx_push & (rx_cnt_after == 3'h4);
         2'b10:   rx_evt = rx_push & (rx_cnt_after == 3'h3);
         default: rx_evt = rx_push;
      endcase
   end
   // =======================================================================
   // Bus channel capture and responses
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         aw_held_q    <= 1'b0;
         w_held_q     <= 1'b0;
         aw_addr_q    <= 5'h00;
         w_data_q     <= 32'h00000000;
         w_strb_q     <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp  <= `RESP_OKAY;
         s_axi_rdata  <= 32'h00000000;
      end else begin
         if (s_axi_awvalid & s_axi_awready) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_held_q    <= 1'b0;
            w_held_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wa_ok ? `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= ra_ok ? `RESP_OKAY : `RESP_SLVERR;
            case (s_axi_araddr)
               // status bits read without side effects
               `REG_STATUS_CONTROL: s_axi_rdata <= {16'h0000, tx_irq_mode_select_q[1], tx_idle_invert_q,
                                        tx_irq_mode_select_q[0], 1'b0, send_break_request_q, tx_enable_q, tx_full,
                                        tx_shift_empty, rx_irq_level_select_q, 5'h00, (rx_cnt_q != 3'h0)};
               `REG_RX_DATA:    s_axi_rdata <= {24'h000000, rx_fifo_q[rx_rd_q]};
               `REG_IRQ_STATUS: s_axi_rdata <= {30'h00000000, irq_status_q};
               `REG_IRQ_MASK:   s_axi_rdata <= {30'h00000000, irq_mask_q};
               `REG_MODE:       s_axi_rdata <= {31'h00000000, infrared_encode_enable_q};
               `REG_BAUD_DIV:   s_axi_rdata <= {16'h0000, baud_div_q};
               default:         s_axi_rdata <= 32'h00000000;
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
   // =======================================================================
   // Control and interrupt registers
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         tx_irq_mode_select_q     <= 2'h0;
         tx_idle_invert_q         <= 1'b0;
         send_break_request_q     <= 1'b0;
         tx_enable_q              <= 1'b0;
         rx_irq_level_select_q    <= 2'h0;
         infrared_encode_enable_q <= 1'b0;
         baud_div_q               <= `BAUD_DIV_RESET;
         irq_status_q             <= 2'h0;
         irq_mask_q               <= 2'h0;
      end else begin
         // bits 9 and 8 are not stored
         if (wr_ctl & w_strb_q[1]) begin
            tx_irq_mode_select_q <= {w_data_q[`BIT_TX_MODE_HI], w_data_q[`BIT_TX_MODE_LO]};
            tx_idle_invert_q     <= w_data_q[`BIT_TX_IDLE_INV];
            tx_enable_q          <= w_data_q[`BIT_TX_ENABLE];
         end
         if (wr_ctl & w_strb_q[0])
            rx_irq_level_select_q <= w_data_q[`BIT_RX_SEL_HI:`BIT_RX_SEL_LO];
         // hardware clears break after the stop bit
         if (wr_ctl & w_strb_q[1] & w_data_q[`BIT_BREAK_REQ])
            send_break_request_q <= 1'b1;
         else if ((tx_last & tx_is_break_q) | (wr_ctl & w_strb_q[1] & ~w_data_q[`BIT_TX_ENABLE]))
            send_break_request_q <= 1'b0;
         if (wr_mode)
            infrared_encode_enable_q <= w_data_q[0];
         if (wr_mask)
            irq_mask_q <= w_data_q[1:0];
         if (wr_baud & w_strb_q[0])
            baud_div_q[7:0] <= w_data_q[7:0];
         if (wr_baud & w_strb_q[1])
            baud_div_q[15:8] <= w_data_q[15:8];
         // Set wins over write-one-to-clear
         irq_status_q <= (irq_status_q & ~(wr_iclr ? w_data_q[1:0] : 2'h0)) | {rx_evt, tx_evt};
      end
   end
   assign irq = |(irq_status_q & irq_mask_q);
   // =======================================================================
   // Transmit buffer and shifter
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         tx_rd_q       <= 2'h0;
         tx_cnt_q      <= 3'h0;
         tx_busy_q     <= 1'b0;
         tx_bit_q      <= 4'h0;
         tx_baud_q     <= 16'h0000;
         tx_shift_q    <= 12'h000;
         tx_is_break_q <= 1'b0;
         tx_line_q     <= 1'b1;
      end else if (!tx_enable_q) begin
         tx_rd_q   <= 2'h0;
         tx_cnt_q  <= 3'h0;
         tx_busy_q <= 1'b0;
         tx_bit_q  <= 4'h0;
         tx_line_q <= 1'b1;
      end else begin
         // Full buffer silently drops the write
         if (wr_txd & ~tx_full)
            tx_fifo_q[tx_rd_q + tx_cnt_q[1:0]] <= w_data_q[7:0];
         tx_cnt_q <= tx_cnt_q + ((wr_txd & ~tx_full) ? 3'h1 : 3'h0) - (tx_load_chr ? 3'h1 : 3'h0);
         if (tx_load) begin
            // break is start, twelve zeros, stop
            tx_is_break_q <= send_break_request_q;
            tx_shift_q    <= send_break_request_q ? 12'h000 : {4'h0, tx_fifo_q[tx_rd_q]};
            tx_rd_q       <= tx_rd_q + (send_break_request_q ? 2'h0 : 2'h1);
            tx_busy_q     <= 1'b1;
            tx_bit_q      <= 4'h1;
            tx_baud_q     <= baud_div_q;
            tx_line_q     <= 1'b0;
         end else if (tx_busy_q) begin
            if (tx_tick) begin
               tx_baud_q <= baud_div_q;
               if (tx_last) begin
                  tx_busy_q <= 1'b0;
                  tx_bit_q  <= 4'h0;
                  tx_line_q <= 1'b1;
               end else begin
                  tx_bit_q   <= tx_bit_q + 4'h1;
                  tx_line_q  <= (tx_bit_q == (tx_is_break_q ? 4'hD : 4'h9)) ? 1'b1 : tx_shift_q[0];
                  tx_shift_q <= {1'b0, tx_shift_q[11:1]};
               end
            end else begin
               tx_baud_q <= tx_baud_q - 16'h0001;
            end
         end
      end
   end
   // =======================================================================
   // Pin drive; encoder pulse shaping is outside this block
   always @(posedge clk_sys) begin
      if (!rst_n)
         serial_tx_pin <= 1'b0;
      else if (!tx_enable_q)
         serial_tx_pin <= port_tx_value;
      // plain line, invert gives idle low
      else if (!infrared_encode_enable_q)
         serial_tx_pin <= tx_line_q ^ tx_idle_invert_q;
      // encoded output idles at invert value
      else
         serial_tx_pin <= (~tx_line_q) ^ tx_idle_invert_q;
   end
   // pin released to the port while disabled
   assign serial_tx_oe_n = ~tx_enable_q;
   // =======================================================================
   // Receiver with four-entry buffer; overrun drops the character
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         rx_busy_q  <= 1'b0;
         rx_bit_q   <= 4'h0;
         rx_baud_q  <= 16'h0000;
         rx_shift_q <= 8'h00;
         rx_rd_q    <= 2'h0;
         rx_cnt_q   <= 3'h0;
      end else begin
         if (!rx_busy_q) begin
            if (!serial_rx_pin) begin
               rx_busy_q <= 1'b1;
               rx_bit_q  <= 4'h0;
               rx_baud_q <= {1'b0, baud_div_q[15:1]};
            end
         end else if (rx_tick) begin
            rx_baud_q <= baud_div_q;
            rx_bit_q  <= rx_bit_q + 4'h1;
            if (rx_bit_q == 4'h0 && serial_rx_pin)
               rx_busy_q <= 1'b0;
            else if (rx_bit_q != 4'h0 && rx_bit_q != 4'h9)
               rx_shift_q <= {serial_rx_pin, rx_shift_q[7:1]};
            if (rx_done)
               rx_busy_q <= 1'b0;
         end else begin
            rx_baud_q <= rx_baud_q - 16'h0001;
         end
         if (rx_push)
            rx_fifo_q[rx_rd_q + rx_cnt_q[1:0]] <= rx_shift_q;
         if (rd_rxd & (rx_cnt_q != 3'h0))
            rx_rd_q <= rx_rd_q + 2'h1;
         rx_cnt_q <= rx_cnt_q + (rx_push ? 3'h1 : 3'h0) - ((rd_rxd & (rx_cnt_q != 3'h0)) ? 3'h1 : 3'h0);
      end
   end
endmodule // uart_stat
`default_nettype wire

// [uart_stat_sva.sv]
`timescale 1ns/1ps
`default_nettype none
`include "uart_stat_defines.vh"
module uart_stat_sva (
   // Clock and reset
   input wire logic        clk_sys,
   input wire logic        rst_n,
   // Register bus
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [4:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // Pins
   input wire logic        serial_tx_oe_n,
   input wire logic        irq
);
   // ==========
   // Bus and pin checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // Read request accepted; the top word is unmapped
   sequence s_ar_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence s_ar_unmapped;
      s_ar_taken ##0 s_axi_araddr[4:2] == 3'h7;
   endsequence
   sequence s_stat_read;
      s_ar_taken ##0 s_axi_araddr == `REG_STATUS_CONTROL;
   endsequence
   // Pin enable must track the transmit enable that software reads back
   AST_OE_DRIVEN: assert property (s_stat_read |=> s_axi_rdata[10] == !$past(serial_tx_oe_n))
      else $error("tx pin enable disagrees with transmit enable");
   AST_RST_QUIET: assert property ($rose(rst_n) |-> !s_axi_bvalid && !s_axi_rvalid && !irq && serial_tx_oe_n)
      else $error("outputs active after reset");
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while data pending");
   AST_AR_ANSWER: assert property (s_ar_taken |=> s_axi_rvalid)
      else $error("read data late");
   AST_UNMAPPED: assert property (s_ar_unmapped |=> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
endmodule // uart_stat_sva
`default_nettype wire

// [serial_peer.sv]
`timescale 1ns/1ps
`default_nettype none
module serial_peer #(
   parameter int BIT_CYC = 8
) (
   // Clock
   input  wire logic clk_sys,
   // Lines seen from the remote end
   input  wire logic line_in,
   output var  logic line_out
);
   // ==========
   // Received characters and frame lengths in bits
   int got_q[$];
   int len_q[$];
   initial line_out = 1'h1;
   // Sender: start, eight bits lsb first, stop; idles high
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'h1, b, 1'h0};
      for (int i = 0; i < 10; i++) begin
         line_out <= f[i];
         repeat (BIT_CYC) @(posedge clk_sys);
      end
   endtask
   // Receiver samples until a high after the data, so a break shows as a long frame
   always begin : rx_frame
      logic [15:0] s;
      int n;
      @(negedge line_in);
      repeat (BIT_CYC / 2) @(negedge clk_sys);
      s = 16'h0;
      n = 0;
      do begin
         s[n] = line_in;
         n++;
         if (!(n >= 10 && s[n - 1])) repeat (BIT_CYC) @(negedge clk_sys);
      end while (n < 16 && !(n >= 10 && s[n - 1]));
      got_q.push_back(s[8:1]);
      len_q.push_back(n);
   end
endmodule // serial_peer
`default_nettype wire

// [tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
   // ==========
   // Stimulus, model state and design
   localparam logic [4:0] A_STAT = 5'h00, A_TX = 5'h04, A_RX = 5'h08, A_IRQ = 5'h0C;
   localparam logic [4:0] A_MASK = 5'h10, A_MODE = 5'h14, A_BAUD = 5'h18;
   logic        clk_sys = 1'h0, rst_n = 1'h0, port_val = 1'h0;
   logic [4:0]  awaddr = 5'h0, araddr = 5'h0;
   logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [31:0] wdata = 32'h0, rd, rdata;
   logic [1:0]  rr, bresp, rresp;
   logic        awready, wready, bvalid, arready, rvalid, tx_pin, oe_n, irq, peer_line;
   int          error_cnt = 0, n_tests = 0, seed = 52964, exp_b;
   int          sent_q[$], rx_q[$];
   uart_stat u_uart_stat (
      .clk_sys(clk_sys), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .serial_rx_pin(peer_line),
      .serial_tx_pin(tx_pin), .serial_tx_oe_n(oe_n), .port_tx_value(port_val), .irq(irq));
   // Divisor 7 gives eight cycles a bit
   serial_peer #(.BIT_CYC(8)) u_serial_peer (.clk_sys(clk_sys), .line_in(tx_pin), .line_out(peer_line));
   // 20 MHz clock
   always #25 clk_sys = ~clk_sys;
   // Compare and count
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] want);
      n_tests++;
      if (got !== want) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, want, got);
      end
   endtask
   // Ready raised late on purpose; read data waits a cycle, but bready rises with bvalid
   task automatic axw(input logic [4:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      while (!(bvalid && bready)) begin
         @(posedge clk_sys);
         if (awvalid && awready) awvalid <= 1'h0;
         if (wvalid && wready) wvalid <= 1'h0;
         if (!awvalid && !wvalid) bready <= 1'h1;
      end
      bready <= 1'h0;
   endtask
   task automatic axr(input logic [4:0] a);
      @(posedge clk_sys);
      araddr <= a;
      arvalid <= 1'h1;
      while (!(rvalid && rready)) begin
         @(posedge clk_sys);
         if (arvalid && arready) arvalid <= 1'h0;
         if (!arvalid) rready <= 1'h1;
      end
      rd = rdata;
      rr = rresp;
      rready <= 1'h0;
   endtask
   // Drop stray frames seen while the pin changed owner
   task automatic flush();
      repeat (150) @(posedge clk_sys);
      u_serial_peer.got_q.delete();
      u_serial_peer.len_q.delete();
   endtask
   task automatic wait_frames(input int n);
      for (int t = 0; t < 3000 && u_serial_peer.got_q.size() < n; t++) @(posedge clk_sys);
      chk("frame_cnt", u_serial_peer.got_q.size() >= n, 1'h1);
      repeat (16) @(posedge clk_sys);
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (20) @(posedge clk_sys);
      rst_n <= 1'h1;
      axr(A_STAT);
      chk("stat_rst", rd[9:8], 2'h1);
      axr(A_BAUD);
      chk("baud_rst", rd, 32'hAD);
      axr(5'h1C);
      chk("bad_resp", rr, 2'h2);
      port_val <= 1'($random(seed));
      repeat (3) @(posedge clk_sys);
      chk("port_pin", tx_pin, port_val);
      chk("port_oe", oe_n, 1'h1);
      port_val <= 1'h1;
      axw(A_BAUD, 32'h7);
      axw(A_MASK, 32'h3);
      axw(A_STAT, 32'h400);
      flush();
      // Every transmit interrupt mode, one character each
      for (int m = 0; m < 4; m++) begin
         axw(A_STAT, 32'h400 + (m / 2) * 32'h8000 + (m % 2) * 32'h2000);
         axw(A_IRQ, 32'h3);
         exp_b = $random(seed) & 32'hFF;
         sent_q.push_back(exp_b);
         axw(A_TX, exp_b);
         axr(A_IRQ);
         chk("tx_irq_load", rd[0], m == 0 || m == 2);
         axr(A_STAT);
         chk("busy", rd[8], 1'h0);
         wait_frames(1);
         chk("frame", u_serial_peer.got_q.pop_front(), sent_q.pop_front());
         axr(A_IRQ);
         chk("tx_irq_done", rd[0], m != 3);
         chk("irq_pin", irq, m != 3);
         chk("tx_oe", oe_n, 1'h0);
      end
      // Back-to-back writes until the buffer refuses one
      axw(A_STAT, 32'h400);
      for (int i = 0; i < 6; i++) begin
         exp_b = $random(seed) & 32'hFF;
         if (i < 5) sent_q.push_back(exp_b);
         axw(A_TX, exp_b);
      end
      axr(A_STAT);
      chk("full", rd[9:8], 2'h2);
      wait_frames(5);
      while (sent_q.size() > 0) chk("burst", u_serial_peer.got_q.pop_front(), sent_q.pop_front());
      axw(A_STAT, 32'h700);
      axr(A_STAT);
      chk("ro_bits", rd[9:8], 2'h1);
      flush();
      // Break frame, then self-clearing request
      axw(A_STAT, 32'hC00);
      axr(A_STAT);
      chk("brk_pending", rd[11], 1'h1);
      wait_frames(1);
      chk("brk_len", u_serial_peer.len_q.pop_front(), 32'hE);
      chk("brk_data", u_serial_peer.got_q.pop_front(), 32'h0);
      axr(A_STAT);
      chk("brk_clear", rd[11], 1'h0);
      // Abort with characters still queued
      for (int i = 0; i < 3; i++)
         axw(A_TX, i);
      repeat (20) @(posedge clk_sys);
      axw(A_STAT, 32'h0);
      port_val <= 1'($random(seed));
      repeat (3) @(posedge clk_sys);
      chk("abort_pin", tx_pin, port_val);
      chk("abort_oe", oe_n, 1'h1);
      axr(A_STAT);
      chk("abort_empty", rd[9:8], 2'h1);
      port_val <= 1'h1;
      flush();
      // Receive thresholds: each character, three, four
      for (int s = 0; s < 4; s++) begin
         axw(A_STAT, s * 32'h40);
         for (int k = 1; k < 5; k++) begin
            axw(A_IRQ, 32'h3);
            exp_b = $random(seed) & 32'hFF;
            rx_q.push_back(exp_b);
            u_serial_peer.send(exp_b[7:0]);
            repeat (8) @(posedge clk_sys);
            axr(A_IRQ);
            chk("rx_irq", rd[1], s < 2 || k == s + 1);
         end
         for (int k = 0; k < 4; k++) begin
            axr(A_RX);
            chk("rx_data", rd[7:0], rx_q.pop_front());
         end
      end
      // Idle level for each invert and encoding choice
      for (int c = 0; c < 4; c++) begin
         axw(A_MODE, c / 2);
         axw(A_STAT, 32'h400 + (c % 2) * 32'h4000);
         repeat (4) @(posedge clk_sys);
         chk("idle_level", tx_pin, (c / 2) ? c % 2 : 1 - c % 2);
      end
      test_done();
   end
   // Watchdog well beyond the expected run length
   initial begin
      repeat (40000) @(posedge clk_sys);
      error_cnt++;
      test_done();
   end
endmodule // tb
bind uart_stat uart_stat_sva u_uart_stat_sva (
   .clk_sys(clk_sys), .rst_n(rst_n), .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .serial_tx_oe_n(serial_tx_oe_n), .irq(irq));
`default_nettype wire
